// >>> logic/smc_pkg.sv
// Shared constants, register map and types of the measurement control link
package smc_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_GAIN_DRIVE   = 8'hb9;
  localparam logic [7:0] ADDR_TEMP_HIGH    = 8'hd1;
  localparam logic [7:0] ADDR_TEMP_LOW     = 8'hd2;
  localparam logic [7:0] ADDR_TEMP_CTRL    = 8'hd3;
  localparam logic [7:0] ADDR_INTEG_PERIOD = 8'hd9;
  localparam logic [7:0] ADDR_INTEG_PAUSE  = 8'hda;
  localparam logic [7:0] ADDR_CHANNEL_SET  = 8'hdb;
  localparam logic [7:0] ADDR_CH_N_LOW     = 8'hdc;
  localparam logic [7:0] ADDR_CH_N_HIGH    = 8'hdd;
  localparam logic [7:0] ADDR_CH_Y_LOW     = 8'hde;
  localparam logic [7:0] ADDR_CH_Y_HIGH    = 8'hdf;
  localparam logic [7:0] ADDR_LED_DRIVE    = 8'hea;
  localparam logic [7:0] ADDR_CH_Z_LOW     = 8'hec;
  localparam logic [7:0] ADDR_CH_Z_HIGH    = 8'hed;
  localparam logic [7:0] ADDR_CH_X_LOW     = 8'hee;
  localparam logic [7:0] ADDR_CH_X_HIGH    = 8'hef;
  localparam logic [7:0] ADDR_ACQ_CTRL     = 8'hfa;
  // Reset values
  localparam logic [7:0] RST_ZERO          = 8'h00;
  localparam logic [7:0] RST_PERIOD        = 8'hff;
  // Field positions and codes
  localparam int         TC_FLAG_BIT       = 7;
  localparam int         TC_START_BIT      = 5;
  localparam int         TC_SRC_LSB        = 0;
  localparam logic [3:0] SRC_CONVERT       = 4'h4;
  localparam logic [3:0] SRC_IDLE          = 4'h0;
  localparam int         TEMP_HIGH_LSB     = 2;
  localparam int         CHANNEL_SET_BIT   = 7;
  localparam int         DRIVE_LIMIT_LSB   = 6;
  localparam int         GAIN_LSB          = 0;
  localparam int         LED_ON_BIT        = 2;
  localparam int         ACQ_LATCH_BIT     = 7;
  localparam int         ACQ_WAIT_BIT      = 3;
  localparam int         ACQ_ENABLE_BIT    = 1;
  localparam int         ACQ_ONE_BIT       = 0;
  // Timing
  localparam int         CLK_PERIOD_PS     = 4000;
  localparam int         STEP_TIME_US      = 2800;
  // Scaled in two steps so the product stays inside a 32-bit int
  localparam int         STEP_CYCLES_DOC   =
    STEP_TIME_US * (1000000 / CLK_PERIOD_PS);
  localparam logic [8:0] STEP_BASE         = 9'h100;
  localparam int         TEMP_CONV_CYCLES  = 16;
  // Host command register offsets
  localparam logic [7:0] HADDR_TARGET      = 8'h00;
  localparam logic [7:0] HADDR_WDATA       = 8'h01;
  localparam logic [7:0] HADDR_GO          = 8'h02;
  localparam logic [7:0] HADDR_STATUS      = 8'h03;
  localparam logic [7:0] HADDR_RDATA       = 8'h04;
  localparam int         GO_WRITE_BIT      = 0;
  localparam int         GO_READ_BIT       = 1;

  typedef enum logic [1:0] {
    ACQ_IDLE  = 2'b00,
    ACQ_INTEG = 2'b01,
    ACQ_PAUSE = 2'b10
  } smc_acq_state_type;

  typedef enum logic [1:0] {
    TMP_IDLE = 2'b00,
    TMP_CONV = 2'b01,
    TMP_POST = 2'b10
  } smc_tmp_state_type;

  typedef enum logic [1:0] {
    HST_IDLE  = 2'b00,
    HST_ISSUE = 2'b01,
    HST_CAPT  = 2'b10
  } smc_host_state_type;

  // Bits that hold state at each writable address; all else is reserved
  function automatic logic [7:0] smc_write_mask(input logic [7:0] a);
    logic [7:0] m;
    m = 8'h00;
    if (a == ADDR_GAIN_DRIVE) m = 8'hc3;
    else if (a == ADDR_TEMP_CTRL) m = 8'haf;
    else if (a == ADDR_INTEG_PERIOD) m = 8'hff;
    else if (a == ADDR_INTEG_PAUSE) m = 8'hff;
    else if (a == ADDR_CHANNEL_SET) m = 8'h80;
    else if (a == ADDR_LED_DRIVE) m = 8'h04;
    else if (a == ADDR_ACQ_CTRL) m = 8'h8b;
    return m;
  endfunction : smc_write_mask
endpackage : smc_pkg

// >>> logic/smc_reg_if.sv
// Register link between the host controller and the sensor device
`timescale 1ns/1ps
`default_nettype none
interface smc_reg_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;

  modport dev  (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd,
                input rdata);
endinterface : smc_reg_if
`default_nettype wire

// >>> logic/smc_device.sv
// Sensor device end: registers, temperature conversion, acquisition timing
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RL1 - High temperature byte holds result bits 9:2
// RL2 - Low temperature byte holds result bits 1:0
// RL3 - Done flag sets; host writes it zero
// RL4 - Start bit begins conversion; zero idles
// RL5 - Host writes source 0100 start, 0000 idle
// RL6 - Host writes reserved bits as zero
// RL7 - Channel set bit picks reported channels
// RL8 - Drive field limits LED pin current
// RL9 - Gain field sets gain of all channels
// RL10 - Integration lasts (256 - value) steps, resets 0xff
// RL11 - Pause lasts (256 - value) steps
// RL12 - Wait bit inserts pause between acquisitions
// RL13 - Latch bit holds results after acquisition
// RL14 - Enable bit runs acquisitions, else none
// RL15 - Host always writes bit 0 as one
// RL16 - N and Y results as byte pairs
// RL17 - Z and X results as byte pairs
// RL18 - LED on bit switches drive pin
// RL19 - Temperature bytes update before done flag
// RL20 - Writes to result addresses are ignored
module smc_device
  import smc_pkg::*;
#(
  parameter int STEP_CYCLES = STEP_CYCLES_DOC
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  smc_reg_if.dev           link,
  input  wire logic [9:0]  temp_sample,
  input  wire logic [15:0] ch_x,
  input  wire logic [15:0] ch_y,
  input  wire logic [15:0] ch_z,
  input  wire logic [15:0] ch_d,
  input  wire logic [15:0] ch_nir,
  output logic             led_drive_on,
  output logic [1:0]       drive_current_limit,
  output logic [1:0]       channel_gain,
  output logic             integrating,
  output logic             acq_done
);
  logic [7:0]        gain_reg, gain_next;
  logic [7:0]        tctrl_reg, tctrl_next;
  logic [7:0]        period_reg, period_next;
  logic [7:0]        pause_reg, pause_next;
  logic [7:0]        chset_reg, chset_next;
  logic [7:0]        led_reg, led_next;
  logic [7:0]        acq_reg, acq_next;
  logic [7:0]        rdata_reg, rdata_next;
  logic [9:0]        temp_reg, temp_next;
  logic [15:0]       res_n_reg, res_n_next, res_y_reg, res_y_next;
  logic [15:0]       res_z_reg, res_z_next, res_x_reg, res_x_next;
  smc_tmp_state_type tst_reg, tst_next;
  logic [11:0]       tcnt_reg, tcnt_next;
  smc_acq_state_type ast_reg, ast_next;
  logic [19:0]       sub_reg, sub_next;
  logic [8:0]        steps_reg, steps_next;
  logic              done_reg, done_next;
  logic [7:0]        wmask, wval;
  logic              wr_tctrl, temp_go, temp_stop, flag_set;
  logic              step_end, period_end;
  logic [15:0]       slot_n, slot_z;

  assign wmask     = smc_write_mask(link.addr);
  assign wval      = link.wdata & wmask;
  assign wr_tctrl  = link.wr && link.addr == ADDR_TEMP_CTRL;
  assign temp_go   = wr_tctrl && link.wdata[TC_START_BIT]                 // RL4
    && link.wdata[TC_SRC_LSB +: 4] == SRC_CONVERT;                      // RL5
  assign temp_stop = wr_tctrl && !temp_go;
  assign flag_set  = tst_reg == TMP_POST;

  // Register writes; only mapped, writable bits are stored
  always_comb begin
    gain_next   = gain_reg;
    period_next = period_reg;
    pause_next  = pause_reg;
    chset_next  = chset_reg;
    led_next    = led_reg;
    acq_next    = acq_reg;
    tctrl_next  = tctrl_reg;
    if (link.wr) begin
      if (link.addr == ADDR_GAIN_DRIVE) gain_next = wval;
      else if (link.addr == ADDR_INTEG_PERIOD) period_next = wval;
      else if (link.addr == ADDR_INTEG_PAUSE) pause_next = wval;
      else if (link.addr == ADDR_CHANNEL_SET) chset_next = wval;
      else if (link.addr == ADDR_LED_DRIVE) led_next = wval;
      else if (link.addr == ADDR_ACQ_CTRL) acq_next = wval;
      else if (link.addr == ADDR_TEMP_CTRL) tctrl_next = wval;
    end // RL20
    // A finishing conversion beats a clearing write in the same cycle
    if (flag_set) tctrl_next[TC_FLAG_BIT] = 1'b1; // RL3
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gain_reg   <= RST_ZERO;
      period_reg <= RST_PERIOD; // RL10
      pause_reg  <= RST_PERIOD;
      chset_reg  <= RST_ZERO;
      led_reg    <= RST_ZERO;
      acq_reg    <= RST_ZERO;
      tctrl_reg  <= RST_ZERO;
    end else begin
      gain_reg   <= gain_next;
      period_reg <= period_next;
      pause_reg  <= pause_next;
      chset_reg  <= chset_next;
      led_reg    <= led_next;
      acq_reg    <= acq_next;
      tctrl_reg  <= tctrl_next;
    end
  end

  // Temperature conversion: result captured one cycle before the flag
  always_comb begin
    tst_next  = tst_reg;
    tcnt_next = tcnt_reg;
    temp_next = temp_reg;
    case (tst_reg)
      TMP_IDLE: begin
        if (temp_go) begin
          tst_next  = TMP_CONV;
          tcnt_next = 12'(TEMP_CONV_CYCLES - 1);
        end
      end
      TMP_CONV: begin
        if (temp_stop) tst_next = TMP_IDLE; // RL4
        else if (tcnt_reg == 12'h000) begin
          temp_next = temp_sample; // RL19
          tst_next  = TMP_POST;
        end else tcnt_next = tcnt_reg - 12'h001;
      end
      default: tst_next = TMP_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tst_reg  <= TMP_IDLE;
      tcnt_reg <= 12'h000;
      temp_reg <= 10'h000;
    end else begin
      tst_reg  <= tst_next;
      tcnt_reg <= tcnt_next;
      temp_reg <= temp_next;
    end
  end

  // Acquisition timing in steps of STEP_CYCLES clocks
  assign step_end   = sub_reg == 20'(STEP_CYCLES - 1);
  assign period_end = step_end && steps_reg == 9'h001;
  assign slot_n = chset_reg[CHANNEL_SET_BIT] ? ch_nir : ch_d; // RL7
  assign slot_z = chset_reg[CHANNEL_SET_BIT] ? ch_z : ch_d; // RL7

  always_comb begin
    ast_next   = ast_reg;
    sub_next   = step_end ? 20'h00000 : sub_reg + 20'h00001;
    steps_next = step_end ? steps_reg - 9'h001 : steps_reg;
    done_next  = 1'b0;
    res_n_next = res_n_reg;
    res_y_next = res_y_reg;
    res_z_next = res_z_reg;
    res_x_next = res_x_reg;
    case (ast_reg)
      ACQ_IDLE: begin
        sub_next = 20'h00000;
        if (acq_reg[ACQ_ENABLE_BIT]) begin // RL14
          ast_next   = ACQ_INTEG;
          steps_next = STEP_BASE - {1'b0, period_reg}; // RL10
        end
      end
      ACQ_INTEG: begin
        if (!acq_reg[ACQ_ENABLE_BIT]) ast_next = ACQ_IDLE; // RL14
        else if (period_end) begin
          done_next = 1'b1;
          if (acq_reg[ACQ_WAIT_BIT]) begin // RL12
            ast_next   = ACQ_PAUSE;
            steps_next = STEP_BASE - {1'b0, pause_reg}; // RL11
          end else steps_next = STEP_BASE - {1'b0, period_reg};
        end
        // Without latching the results follow the live channels
        if (period_end || !acq_reg[ACQ_LATCH_BIT]) begin // RL13
          res_n_next = slot_n;
          res_y_next = ch_y;
          res_z_next = slot_z;
          res_x_next = ch_x;
        end
      end
      ACQ_PAUSE: begin
        if (!acq_reg[ACQ_ENABLE_BIT]) ast_next = ACQ_IDLE;
        else if (period_end) begin
          ast_next   = ACQ_INTEG;
          steps_next = STEP_BASE - {1'b0, period_reg};
        end
      end
      default: ast_next = ACQ_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ast_reg   <= ACQ_IDLE;
      sub_reg   <= 20'h00000;
      steps_reg <= 9'h000;
      done_reg  <= 1'b0;
      res_n_reg <= 16'h0000;
      res_y_reg <= 16'h0000;
      res_z_reg <= 16'h0000;
      res_x_reg <= 16'h0000;
    end else begin
      ast_reg   <= ast_next;
      sub_reg   <= sub_next;
      steps_reg <= steps_next;
      done_reg  <= done_next;
      res_n_reg <= res_n_next;
      res_y_reg <= res_y_next;
      res_z_reg <= res_z_next;
      res_x_reg <= res_x_next;
    end
  end

  // Read path: data stand in the cycle after the read strobe
  always_comb begin
    rdata_next = 8'h00;
    if (link.rd) begin
      if (link.addr == ADDR_GAIN_DRIVE) rdata_next = gain_reg;
      else if (link.addr == ADDR_TEMP_HIGH)
        rdata_next = temp_reg[9:TEMP_HIGH_LSB]; // RL1
      else if (link.addr == ADDR_TEMP_LOW)
        rdata_next = {6'h00, temp_reg[1:0]}; // RL2
      else if (link.addr == ADDR_TEMP_CTRL) rdata_next = tctrl_reg;
      else if (link.addr == ADDR_INTEG_PERIOD) rdata_next = period_reg;
      else if (link.addr == ADDR_INTEG_PAUSE) rdata_next = pause_reg;
      else if (link.addr == ADDR_CHANNEL_SET) rdata_next = chset_reg;
      else if (link.addr == ADDR_CH_N_LOW) rdata_next = res_n_reg[7:0]; // RL16
      else if (link.addr == ADDR_CH_N_HIGH) rdata_next = res_n_reg[15:8];
      else if (link.addr == ADDR_CH_Y_LOW) rdata_next = res_y_reg[7:0]; // RL16
      else if (link.addr == ADDR_CH_Y_HIGH) rdata_next = res_y_reg[15:8];
      else if (link.addr == ADDR_LED_DRIVE) rdata_next = led_reg;
      else if (link.addr == ADDR_CH_Z_LOW) rdata_next = res_z_reg[7:0]; // RL17
      else if (link.addr == ADDR_CH_Z_HIGH) rdata_next = res_z_reg[15:8];
      else if (link.addr == ADDR_CH_X_LOW) rdata_next = res_x_reg[7:0]; // RL17
      else if (link.addr == ADDR_CH_X_HIGH) rdata_next = res_x_reg[15:8];
      else if (link.addr == ADDR_ACQ_CTRL) rdata_next = acq_reg;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rdata_reg <= 8'h00;
    else rdata_reg <= rdata_next;
  end

  assign link.rdata          = rdata_reg;
  assign led_drive_on        = led_reg[LED_ON_BIT]; // RL18
  assign drive_current_limit = gain_reg[DRIVE_LIMIT_LSB +: 2]; // RL8
  assign channel_gain        = gain_reg[GAIN_LSB +: 2]; // RL9
  assign integrating         = ast_reg == ACQ_INTEG;
  assign acq_done            = done_reg;
endmodule : smc_device
`default_nettype wire

// >>> logic/smc_host.sv
// Host controller end: turns command registers into link accesses
`timescale 1ns/1ps
`default_nettype none
module smc_host
  import smc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  smc_reg_if.host         link,
  input  wire logic [7:0] cpu_addr,
  input  wire logic [7:0] cpu_wdata,
  input  wire logic       cpu_wr,
  input  wire logic       cpu_rd,
  output logic [7:0]      cpu_rdata
);
  smc_host_state_type st_reg, st_next;
  logic [7:0] target_reg, target_next;
  logic [7:0] wdata_reg, wdata_next;
  logic [7:0] rbuf_reg, rbuf_next;
  logic [7:0] laddr_reg, laddr_next;
  logic [7:0] lwdata_reg, lwdata_next;
  logic       lwr_reg, lwr_next;
  logic       lrd_reg, lrd_next;
  logic [7:0] cpu_rdata_reg, cpu_rdata_next;
  logic       go_wr, go_rd;

  // Forces the device's fixed write conventions onto every write
  function automatic logic [7:0] smc_sanitize(input logic [7:0] a,
                                              input logic [7:0] d);
    logic [7:0] v;
    v = d & smc_write_mask(a); // RL6
    if (a == ADDR_TEMP_CTRL) begin
      v[TC_FLAG_BIT] = 1'b0; // RL3
      v[TC_SRC_LSB +: 4] = v[TC_START_BIT] ? SRC_CONVERT : SRC_IDLE; // RL5
    end
    if (a == ADDR_ACQ_CTRL) v[ACQ_ONE_BIT] = 1'b1; // RL15
    return v;
  endfunction : smc_sanitize

  assign go_wr = cpu_wr && cpu_addr == HADDR_GO
    && cpu_wdata[GO_WRITE_BIT];
  assign go_rd = cpu_wr && cpu_addr == HADDR_GO
    && cpu_wdata[GO_READ_BIT];

  always_comb begin
    st_next     = st_reg;
    target_next = target_reg;
    wdata_next  = wdata_reg;
    rbuf_next   = rbuf_reg;
    laddr_next  = laddr_reg;
    lwdata_next = lwdata_reg;
    lwr_next    = 1'b0;
    lrd_next    = 1'b0;
    if (cpu_wr && cpu_addr == HADDR_TARGET) target_next = cpu_wdata;
    else if (cpu_wr && cpu_addr == HADDR_WDATA) wdata_next = cpu_wdata;
    case (st_reg)
      HST_IDLE: begin
        // Orders that arrive while busy are dropped
        if (go_wr || go_rd) begin
          st_next     = HST_ISSUE;
          laddr_next  = target_reg;
          lwdata_next = smc_sanitize(target_reg, wdata_reg);
          lwr_next    = go_wr;
          lrd_next    = !go_wr;
        end
      end
      HST_ISSUE: st_next = lrd_reg ? HST_CAPT : HST_IDLE;
      HST_CAPT: begin
        rbuf_next = link.rdata;
        st_next   = HST_IDLE;
      end
      default: st_next = HST_IDLE;
    endcase
  end

  always_comb begin
    cpu_rdata_next = 8'h00;
    if (cpu_rd) begin
      if (cpu_addr == HADDR_TARGET) cpu_rdata_next = target_reg;
      else if (cpu_addr == HADDR_WDATA) cpu_rdata_next = wdata_reg;
      else if (cpu_addr == HADDR_STATUS)
        cpu_rdata_next = {7'h00, st_reg != HST_IDLE};
      else if (cpu_addr == HADDR_RDATA) cpu_rdata_next = rbuf_reg;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg        <= HST_IDLE;
      target_reg    <= 8'h00;
      wdata_reg     <= 8'h00;
      rbuf_reg      <= 8'h00;
      laddr_reg     <= 8'h00;
      lwdata_reg    <= 8'h00;
      lwr_reg       <= 1'b0;
      lrd_reg       <= 1'b0;
      cpu_rdata_reg <= 8'h00;
    end else begin
      st_reg        <= st_next;
      target_reg    <= target_next;
      wdata_reg     <= wdata_next;
      rbuf_reg      <= rbuf_next;
      laddr_reg     <= laddr_next;
      lwdata_reg    <= lwdata_next;
      lwr_reg       <= lwr_next;
      lrd_reg       <= lrd_next;
      cpu_rdata_reg <= cpu_rdata_next;
    end
  end

  assign link.addr  = laddr_reg;
  assign link.wdata = lwdata_reg;
  assign link.wr    = lwr_reg;
  assign link.rd    = lrd_reg;
  assign cpu_rdata  = cpu_rdata_reg;
endmodule : smc_host
`default_nettype wire

// >>> logic/smc_unused.sv
// Intentionally empty
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> testbench/smc_link_asserts.sv
// Concurrent checks on the register link and the device drive outputs
`timescale 1ns/1ps
`default_nettype none
module smc_link_asserts
  import smc_pkg::*;
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       led_drive_on,
  input wire logic [1:0] drive_current_limit,
  input wire logic [1:0] channel_gain,
  input wire logic       integrating,
  input wire logic       acq_done
);
  logic [7:0] wd_reg;

  // Last cycle's write data, so outputs can be tied to the write itself
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) wd_reg <= 8'h00;
    else wd_reg <= wdata;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_wr(a);
    wr && addr == a;
  endsequence
  sequence s_rd(a);
    rd && addr == a;
  endsequence
  sequence s_acq_off;
    wr && addr == ADDR_ACQ_CTRL && !wdata[ACQ_ENABLE_BIT];
  endsequence

  a_read_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not idle");
  a_gain_read: assert property (
    s_rd(ADDR_GAIN_DRIVE) |=>
      rdata == {drive_current_limit, 4'h0, channel_gain})
    else $error("gain readback differs from outputs");
  a_gain_out: assert property (
    s_wr(ADDR_GAIN_DRIVE) |=> drive_current_limit == wd_reg[7:6]
      && channel_gain == wd_reg[1:0])
    else $error("gain outputs not updated");
  a_led_read: assert property (
    s_rd(ADDR_LED_DRIVE) |=> rdata == {5'h00, led_drive_on, 2'h0})
    else $error("led readback differs from pin");
  a_led_out: assert property (
    s_wr(ADDR_LED_DRIVE) |=> led_drive_on == wd_reg[LED_ON_BIT])
    else $error("led pin not updated");
  a_flag_zero: assert property (
    s_wr(ADDR_TEMP_CTRL) |-> !wdata[TC_FLAG_BIT])
    else $error("done flag written as one");
  a_src_code: assert property (
    s_wr(ADDR_TEMP_CTRL) |->
      wdata[3:0] == (wdata[TC_START_BIT] ? SRC_CONVERT : SRC_IDLE))
    else $error("source field code wrong");
  a_one_bit: assert property (
    s_wr(ADDR_ACQ_CTRL) |-> wdata[ACQ_ONE_BIT])
    else $error("acquisition write without bit 0");
  a_bank_reserved_bits: assert property (
    s_wr(ADDR_CHANNEL_SET) |-> wdata[6:0] == 7'h00)
    else $error("reserved bits written nonzero");
  a_acq_off: assert property (
    s_acq_off |-> ##2 (!integrating) [*2])
    else $error("integration runs while disabled");
  a_done_src: assert property (
    $rose(acq_done) |-> $past(integrating) ##1 !acq_done)
    else $error("done pulse not at end of integration");
endmodule : smc_link_asserts
`default_nettype wire

// >>> testbench/smc_bench.sv
// Bench for the host controller and sensor device joined on one link
`timescale 1ns/1ps
`default_nettype none
module smc_bench
  import smc_pkg::*;
;
  // Short 4-cycle steps keep every period at 64 cycles or fewer
  localparam int STEP = 4;
  logic        clk, rstn, cpu_wr, cpu_rd, led_on, integ, acq_done;
  logic [7:0]  cpu_addr, cpu_wdata, cpu_rdata;
  logic [9:0]  temp_sample;
  logic [15:0] ch_x, ch_y, ch_z, ch_d, ch_nir;
  logic [1:0]  drv, gain;
  int          n_fail, cmp_count;

  smc_reg_if lnk ();
  smc_device #(.STEP_CYCLES(STEP)) i_smc_device (
    .clk(clk), .rstn(rstn), .link(lnk.dev), .temp_sample(temp_sample),
    .ch_x(ch_x), .ch_y(ch_y), .ch_z(ch_z), .ch_d(ch_d), .ch_nir(ch_nir),
    .led_drive_on(led_on), .drive_current_limit(drv),
    .channel_gain(gain), .integrating(integ), .acq_done(acq_done));
  smc_host i_smc_host (.clk(clk), .rstn(rstn), .link(lnk.host),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata));
  smc_link_asserts i_smc_link_asserts (.clk(clk), .rstn(rstn),
    .addr(lnk.addr), .wdata(lnk.wdata), .wr(lnk.wr), .rd(lnk.rd),
    .rdata(lnk.rdata), .led_drive_on(led_on),
    .drive_current_limit(drv), .channel_gain(gain),
    .integrating(integ), .acq_done(acq_done));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic end_sim;
    if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic check(input string what, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      n_fail++;
    end
  endtask : check

  task automatic cpu_wr8(input logic [7:0] a, d);
    @(posedge clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge clk);
    cpu_wr <= 1'b0;
  endtask : cpu_wr8

  task automatic cpu_rd8(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge clk);
    cpu_rd <= 1'b0;
    #1 d = cpu_rdata;
  endtask : cpu_rd8

  task automatic wait_idle;
    logic [7:0] s;
    s = 8'h01;
    for (int i = 0; i < 8 && s[0] !== 1'b0; i++) cpu_rd8(HADDR_STATUS, s);
    if (s[0] !== 1'b0) begin
      n_fail++;
      end_sim();
    end
  endtask : wait_idle

  task automatic dev_wr(input logic [7:0] a, d);
    cpu_wr8(HADDR_TARGET, a);
    cpu_wr8(HADDR_WDATA, d);
    cpu_wr8(HADDR_GO, 8'h01);
    wait_idle();
  endtask : dev_wr

  task automatic dev_rd(input logic [7:0] a, output logic [7:0] d);
    cpu_wr8(HADDR_TARGET, a);
    cpu_wr8(HADDR_GO, 8'h02);
    wait_idle();
    cpu_rd8(HADDR_RDATA, d);
  endtask : dev_rd

  task automatic expect_reg(input string n, input logic [7:0] a, e);
    logic [7:0] d;
    dev_rd(a, d);
    check(n, {8'h00, d}, {8'h00, e});
  endtask : expect_reg

  // Counts edges while a flag holds lvl; sel picks acq_done over integ
  task automatic count_while(input bit sel, input logic lvl, output int n);
    for (n = 0; n < 2000; n++) begin
      if ((sel ? acq_done : integ) !== lvl) break;
      @(posedge clk);
      #1;
    end
    if (n == 2000) begin
      n_fail++;
      end_sim();
    end
  endtask : count_while

  function automatic logic [15:0] slot(input logic [7:0] a, input logic b);
    case (a & 8'hfe)
      ADDR_CH_N_LOW: return b ? ch_nir : ch_d;
      ADDR_CH_Y_LOW: return ch_y;
      ADDR_CH_Z_LOW: return b ? ch_z : ch_d;
      default: return ch_x;
    endcase
  endfunction : slot

  task automatic t_reset;
    check("outputs", {11'h0, led_on, drv, gain}, 16'h0);
    expect_reg("period", ADDR_INTEG_PERIOD, RST_PERIOD);
    expect_reg("pause", ADDR_INTEG_PAUSE, RST_PERIOD);
    expect_reg("temp ctrl", ADDR_TEMP_CTRL, RST_ZERO);
    expect_reg("acq ctrl", ADDR_ACQ_CTRL, RST_ZERO);
    expect_reg("unmapped", 8'h10, 8'h00);
  endtask : t_reset

  task automatic t_drive;
    for (int i = 0; i < 4; i++) begin
      dev_wr(ADDR_GAIN_DRIVE, {i[1:0], 4'hf, i[1:0]});
      check("drive", {14'h0, drv}, 16'(i));
      check("gain", {14'h0, gain}, 16'(i));
      expect_reg("gain rb", ADDR_GAIN_DRIVE, {i[1:0], 4'h0, i[1:0]});
    end
    dev_wr(ADDR_LED_DRIVE, 8'hff);
    check("led on", {15'h0, led_on}, 16'h1);
    expect_reg("led rb", ADDR_LED_DRIVE, 8'h04);
    dev_wr(ADDR_LED_DRIVE, 8'hfb);
    check("led off", {15'h0, led_on}, 16'h0);
  endtask : t_drive

  task automatic t_temp;
    logic [7:0] d, hi;
    hi = temp_sample[9:2];
    // Host must clean this to start code 0x24
    dev_wr(ADDR_TEMP_CTRL, 8'hf0);
    d = 8'h00;
    for (int k = 0; k < 10 && d[7] !== 1'b1; k++) dev_rd(ADDR_TEMP_CTRL, d);
    check("flag", {8'h0, d}, 16'h00a4);
    expect_reg("temp hi", ADDR_TEMP_HIGH, hi);
    expect_reg("temp lo", ADDR_TEMP_LOW, {6'h0, temp_sample[1:0]});
    dev_wr(ADDR_TEMP_HIGH, 8'h00);
    @(posedge clk);
    temp_sample <= 10'h0cc;
    dev_wr(ADDR_TEMP_CTRL, 8'h00);
    expect_reg("flag clr", ADDR_TEMP_CTRL, 8'h00);
    dev_wr(ADDR_TEMP_CTRL, 8'h20);
    dev_wr(ADDR_TEMP_CTRL, 8'h00);
    repeat (40) @(posedge clk);
    expect_reg("abort", ADDR_TEMP_CTRL, 8'h00);
    expect_reg("hold", ADDR_TEMP_HIGH, hi);
  endtask : t_temp

  task automatic t_acq;
    int n;
    dev_wr(ADDR_INTEG_PERIOD, 8'hfe);
    dev_wr(ADDR_INTEG_PAUSE, 8'hfd);
    dev_wr(ADDR_ACQ_CTRL, 8'h0a);
    count_while(1'b0, 1'b1, n);
    count_while(1'b0, 1'b0, n);
    count_while(1'b0, 1'b1, n);
    check("integ len", 16'(n), 16'((256 - 'hfe) * STEP));
    count_while(1'b0, 1'b0, n);
    check("pause len", 16'(n), 16'((256 - 'hfd) * STEP));
    dev_wr(ADDR_ACQ_CTRL, 8'h02);
    count_while(1'b1, 1'b0, n);
    count_while(1'b1, 1'b1, n);
    count_while(1'b1, 1'b0, n);
    check("no pause", 16'(n), 16'((256 - 'hfe) * STEP - 1));
    dev_wr(ADDR_ACQ_CTRL, 8'h00);
    n = 0;
    repeat (60) begin
      @(posedge clk);
      #1;
      if (integ !== 1'b0 || acq_done !== 1'b0) n++;
    end
    check("idle", 16'(n), 16'h0);
  endtask : t_acq

  task automatic t_results;
    logic [7:0]  a;
    logic [15:0] e;
    int          n;
    dev_wr(ADDR_ACQ_CTRL, 8'h02);
    count_while(1'b1, 1'b0, n);
    for (int b = 0; b < 2; b++) begin
      dev_wr(ADDR_CHANNEL_SET, b[0] ? 8'hff : 8'h00);
      for (int k = 0; k < 8; k++) begin
        a = (k < 4) ? ADDR_CH_N_LOW + 8'(k) : ADDR_CH_Z_LOW + 8'(k - 4);
        e = slot(a, b[0]);
        expect_reg("result", a, a[0] ? e[15:8] : e[7:0]);
      end
    end
    expect_reg("bank rb", ADDR_CHANNEL_SET, 8'h80);
    dev_wr(ADDR_CH_X_LOW, 8'h00);
    expect_reg("ro write", ADDR_CH_X_LOW, ch_x[7:0]);
  endtask : t_results

  task automatic t_latch;
    logic [15:0] old;
    int          n;
    old = ch_x;
    dev_wr(ADDR_INTEG_PERIOD, 8'hf0);
    dev_wr(ADDR_ACQ_CTRL, 8'h82);
    count_while(1'b1, 1'b1, n);
    count_while(1'b1, 1'b0, n);
    @(posedge clk);
    ch_x <= ~old;
    expect_reg("latched", ADDR_CH_X_HIGH, old[15:8]);
    count_while(1'b1, 1'b0, n);
    expect_reg("updated", ADDR_CH_X_HIGH, ~old[15:8]);
  endtask : t_latch

  initial begin
    n_fail = 0;
    cmp_count = 0;
    rstn = 1'b0;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_addr = 8'h00;
    cpu_wdata = 8'h00;
    temp_sample = 10'h2b5;
    ch_x = 16'h1a2b;
    ch_y = 16'h3c4d;
    ch_z = 16'h5e6f;
    ch_d = 16'h7081;
    ch_nir = 16'h92a3;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_drive();
    t_temp();
    t_acq();
    t_results();
    t_latch();
    end_sim();
  end
endmodule : smc_bench
`default_nettype wire
